// [hdl/ldr_cell.sv]
// Lookup table memory cell with its APB configuration registers.
// Overview of operation
// - Two independent 16x1 memories, separate data.
// - One 32x1 memory, one data path.
// - One table memory, other keeps logic.
// - Synchronous writes on selected clock edge.
// - Asynchronous writes follow write enable level.
// - One timing mode governs both tables.
// - Single port shares read/write address.
// - Dual port: one write, two reads.
// - Same-cycle read and write allowed.
// - Reads identical in 16x2 and dual port modes.
// - Four inputs address one table cell.
// - Control inputs become data and enable.
// - 32x1 uses high data as address.
// - Outputs leave directly or via flip-flops.
// - Contents preset with user values.
`timescale 1ns/10ps
`default_nettype none
module ldr_cell
    import ldr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  lut_a_address,
    input  wire logic [3:0]  lut_b_address,
    input  wire logic        ctrl_in_zero,
    input  wire logic        ctrl_in_one,
    input  wire logic        ctrl_in_two,
    input  wire logic        cell_clk,
    output logic             lut_a_out,
    output logic             lut_b_out,
    output logic             lut_a_ff,
    output logic             lut_b_ff,
    output logic             h_out
);

    logic [LDR_PIN_W-1:0] pin_raw;
    logic [LDR_PIN_W-1:0] pin_s1_q;
    logic [LDR_PIN_W-1:0] pin_s2_q;
    logic                 clk_s3_q;
    logic [3:0]           a_addr;
    logic [3:0]           b_addr;
    logic                 write_data_lo;
    logic                 write_data_hi;
    logic                 wr_strobe;
    logic                 clk_rise;
    logic                 clk_fall;
    logic                 clk_edge;
    ldr_cfg_t             cfg_q;
    logic [31:0]          logic_q;
    logic                 is_a_ram;
    logic                 is_b_ram;
    logic                 is_16x2;
    logic                 is_32x1;
    logic                 is_dual;
    logic                 ram_mode;
    logic                 wr_ok;
    ldr_wr_t              wr_a;
    ldr_wr_t              wr_b;
    logic [3:0]           raddr_b;
    logic                 rd_a;
    logic                 rd_b;
    logic [31:0]          image;
    logic                 load;
    logic [3:0]           a_addr_p_q;
    logic [3:0]           b_addr_p_q;
    logic                 hi_p_q;
    logic                 out_a_d;
    logic                 out_b_d;
    logic                 h_d;
    logic                 acc;
    logic                 done;
    logic                 sel_cfg;
    logic                 sel_logic;
    logic                 sel_content;
    logic                 sel_status;
    logic                 mapped;
    logic [31:0]          rdata_d;

    // Pins from the user side pass two flip-flops before any use.
    assign pin_raw = {cell_clk, ctrl_in_two, ctrl_in_one, ctrl_in_zero,
                      lut_b_address, lut_a_address};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            clk_s3_q <= 1'b0;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            clk_s3_q <= pin_s2_q[LDR_PIN_CLK];
        end
    end

    // The control inputs turn into write data and write enable.
    assign a_addr        = pin_s2_q[3:0];
    assign b_addr        = pin_s2_q[LDR_PIN_ADDR_B+3:LDR_PIN_ADDR_B];
    assign write_data_lo = pin_s2_q[LDR_PIN_TWO];
    assign write_data_hi = pin_s2_q[LDR_PIN_ONE];
    assign wr_strobe     = pin_s2_q[LDR_PIN_ZERO];

    assign clk_rise = pin_s2_q[LDR_PIN_CLK] & ~clk_s3_q;
    assign clk_fall = ~pin_s2_q[LDR_PIN_CLK] & clk_s3_q;
    assign clk_edge = cfg_q.neg_edge ? clk_fall : clk_rise;

    assign is_a_ram = cfg_q.mode == LDR_A_RAM;
    assign is_b_ram = cfg_q.mode == LDR_B_RAM;
    assign is_16x2  = cfg_q.mode == LDR_16X2;
    assign is_32x1  = cfg_q.mode == LDR_32X1;
    assign is_dual  = cfg_q.mode == LDR_DUAL;
    assign ram_mode = is_a_ram | is_b_ram | is_16x2 | is_32x1 | is_dual;

    // One timing bit rules both tables; synchronous writes need the edge.
    assign wr_ok = ram_mode & wr_strobe & (cfg_q.async_wr | clk_edge);

    assign wr_a.we   = wr_ok & (is_a_ram | is_16x2 | is_dual | (is_32x1 & ~write_data_hi));
    assign wr_a.addr = a_addr;
    assign wr_a.din  = write_data_lo;

    assign wr_b.we   = wr_ok & (is_b_ram | is_16x2 | is_dual | (is_32x1 & write_data_hi));
    assign wr_b.addr = (is_16x2 | is_b_ram) ? b_addr : a_addr;
    assign wr_b.din  = (is_16x2 | is_b_ram) ? write_data_hi : write_data_lo;

    // The second read port keeps its own address except in 32x1 mode, where it reads at the port A address.
    assign raddr_b = is_32x1 ? a_addr : b_addr;

    assign load = done & pwrite & sel_content;

    ldr_lut_mem u_mem (
        .clk       (pclk),
        .load      (load),
        .load_data (pwdata),
        .wr_a      (wr_a),
        .wr_b      (wr_b),
        .raddr_a   (a_addr),
        .raddr_b   (raddr_b),
        .rd_a_q    (rd_a),
        .rd_b_q    (rd_b),
        .image     (image)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            a_addr_p_q <= 4'h0;
            b_addr_p_q <= 4'h0;
            hi_p_q     <= 1'b0;
        end
        else
        begin
            a_addr_p_q <= a_addr;
            b_addr_p_q <= b_addr;
            hi_p_q     <= write_data_hi;
        end
    end

    // Read paths select the same way whatever the write mode.
    always_comb
    begin
        out_a_d = 1'b0;
        out_b_d = 1'b0;
        unique case (cfg_q.mode)
            LDR_LOGIC:
            begin
                out_a_d = logic_q[{1'b0, a_addr_p_q}];
                out_b_d = logic_q[{1'b1, b_addr_p_q}];
            end
            LDR_A_RAM:
            begin
                out_a_d = rd_a;
                out_b_d = logic_q[{1'b1, b_addr_p_q}];
            end
            LDR_B_RAM:
            begin
                out_a_d = logic_q[{1'b0, a_addr_p_q}];
                out_b_d = rd_b;
            end
            LDR_32X1:
            begin
                out_a_d = hi_p_q ? rd_b : rd_a;
                out_b_d = hi_p_q ? rd_b : rd_a;
            end
            LDR_16X2, LDR_DUAL:
            begin
                out_a_d = rd_a;
                out_b_d = rd_b;
            end
            default:
            begin
                out_a_d = 1'b0;
                out_b_d = 1'b0;
            end
        endcase
    end

    assign h_d = cfg_q.h_tab[{hi_p_q, out_a_d, out_b_d}];

    // Outputs leave directly and can also be caught on the cell clock edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lut_a_out <= 1'b0;
            lut_b_out <= 1'b0;
            h_out     <= 1'b0;
            lut_a_ff  <= 1'b0;
            lut_b_ff  <= 1'b0;
        end
        else
        begin
            lut_a_out <= out_a_d;
            lut_b_out <= out_b_d;
            h_out     <= h_d;
            if (clk_edge)
            begin
                lut_a_ff <= out_a_d;
                lut_b_ff <= out_b_d;
            end
        end
    end

    // Register access answers after one wait state.
    assign acc         = psel & penable;
    assign done        = acc & pready;
    assign sel_cfg     = paddr == LDR_OFF_CFG;
    assign sel_logic   = paddr == LDR_OFF_LOGIC;
    assign sel_content = paddr == LDR_OFF_CONTENT;
    assign sel_status  = paddr == LDR_OFF_STATUS;
    assign mapped      = sel_cfg | sel_logic | sel_content | sel_status;

    assign rdata_d = sel_cfg     ? {19'h0_0000, cfg_q} :
                     sel_logic   ? logic_q :
                     sel_content ? image :
                     sel_status  ? {27'h000_0000, h_out, lut_b_ff, lut_a_ff,
                                    lut_b_out, lut_a_out} :
                                   32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= acc & ~pready;
            pslverr <= acc & ~pready & ~mapped;
            prdata  <= (acc & ~pready & ~pwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q   <= LDR_CFG_RST;
            logic_q <= LDR_LOGIC_RST;
        end
        else
        begin
            if (done & pwrite & sel_cfg)
            begin
                cfg_q <= pwdata[12:0];
            end
            if (done & pwrite & sel_logic)
            begin
                logic_q <= pwdata;
            end
        end
    end

    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_wait_s;
        psel && penable && !pready;
    endsequence

    sequence apb_answer_s;
        pready ##1 !pready;
    endsequence

    apb_answer_a: assert property (apb_wait_s |=> apb_answer_s)
        else $error("APB answer not one cycle after access.");

    sync_edge_a: assert property (!cfg_q.async_wr && (wr_a.we || wr_b.we) |->
        (cfg_q.neg_edge ? $fell(pin_s2_q[LDR_PIN_CLK]) : $rose(pin_s2_q[LDR_PIN_CLK])))
        else $error("Synchronous write without a clock edge.");

    async_level_a: assert property (cfg_q.async_wr && ram_mode && wr_strobe |-> wr_a.we || wr_b.we)
        else $error("Asynchronous strobe did not write.");

    pair_16x2_a: assert property (is_16x2 |-> wr_a.we == wr_b.we && wr_b.din == write_data_hi)
        else $error("Paired tables did not write together.");

    split_32x1_a: assert property (is_32x1 && wr_ok |-> wr_b.we == write_data_hi && wr_a.we != wr_b.we)
        else $error("Wide mode wrote the wrong half.");

    logic_keep_a: assert property (is_a_ram |-> !wr_b.we)
        else $error("Logic table was written.");

    dual_copy_a: assert property (is_dual && wr_a.we |-> wr_b.we && wr_b.addr == wr_a.addr)
        else $error("Dual port copies diverged.");

    read_path_a: assert property (is_16x2 ##1 is_16x2 |-> lut_b_out == $past(rd_b))
        else $error("Read output not from table.");

    write_read_a: assert property (wr_a.we && !load |=> image[$past(wr_a.addr)] == $past(wr_a.din))
        else $error("Written data not stored at edge.");

endmodule : ldr_cell
`default_nettype wire

// [hdl/ldr_lut_mem.sv]
// Two sixteen-bit lookup table arrays with write ports and registered reads.
`timescale 1ns/10ps
`default_nettype none
module ldr_lut_mem
    import ldr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        load,
    input  wire logic [31:0] load_data,
    input  var  ldr_wr_t     wr_a,
    input  var  ldr_wr_t     wr_b,
    input  wire logic [3:0]  raddr_a,
    input  wire logic [3:0]  raddr_b,
    output logic             rd_a_q,
    output logic             rd_b_q,
    output logic [31:0]      image
);

    // Contents start from the configured image and no reset touches them.
    logic [15:0] cell_a_q = LDR_INIT_A;
    logic [15:0] cell_b_q = LDR_INIT_B;

    assign image = {cell_b_q, cell_a_q};

    always_ff @(posedge clk)
    begin
        if (load)
        begin
            cell_a_q <= load_data[15:0];
            cell_b_q <= load_data[31:16];
        end
        else
        begin
            if (wr_a.we)
            begin
                cell_a_q[wr_a.addr] <= wr_a.din;
            end
            if (wr_b.we)
            begin
                cell_b_q[wr_b.addr] <= wr_b.din;
            end
        end
    end

    // Each four-bit address selects one cell of its table.
    always_ff @(posedge clk)
    begin
        rd_a_q <= cell_a_q[raddr_a];
        rd_b_q <= cell_b_q[raddr_b];
    end

endmodule : ldr_lut_mem
`default_nettype wire

// [hdl/ldr_pkg.sv]
// Constants and types shared by the lookup table memory cell files.
package ldr_pkg;

    localparam logic [7:0]  LDR_OFF_CFG     = 8'h00;
    localparam logic [7:0]  LDR_OFF_LOGIC   = 8'h04;
    localparam logic [7:0]  LDR_OFF_CONTENT = 8'h08;
    localparam logic [7:0]  LDR_OFF_STATUS  = 8'h0c;

    localparam logic [31:0] LDR_LOGIC_RST   = 32'h0000_0000;
    localparam logic [15:0] LDR_INIT_A      = 16'h0000;
    localparam logic [15:0] LDR_INIT_B      = 16'h0000;

    localparam int          LDR_PIN_W       = 12;
    localparam int          LDR_PIN_ADDR_B  = 4;
    localparam int          LDR_PIN_ZERO    = 8;
    localparam int          LDR_PIN_ONE     = 9;
    localparam int          LDR_PIN_TWO     = 10;
    localparam int          LDR_PIN_CLK     = 11;

    typedef enum logic [2:0] {
        LDR_LOGIC,
        LDR_A_RAM,
        LDR_B_RAM,
        LDR_16X2,
        LDR_32X1,
        LDR_DUAL
    } ldr_mode_t;

    typedef struct packed {
        logic [7:0] h_tab;
        logic       neg_edge;
        logic       async_wr;
        logic [2:0] mode;
    } ldr_cfg_t;

    localparam ldr_cfg_t    LDR_CFG_RST     = '0;

    typedef struct packed {
        logic       we;
        logic [3:0] addr;
        logic       din;
    } ldr_wr_t;

endpackage : ldr_pkg

// [tb/ldr_cell_test.sv]
// Self-checking testbench for the lookup table memory cell.
`timescale 1ns/10ps
`default_nettype none
module ldr_cell_test
    import ldr_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  a_addr;
    logic [3:0]  b_addr;
    logic        zero;
    logic        one;
    logic        two;
    logic        cclk;
    logic        lut_a_out;
    logic        lut_b_out;
    logic        lut_a_ff;
    logic        lut_b_ff;
    logic        h_out;
    int          miscompares;
    int          num_checks;
    int          cycles;

    ldr_user_model i_user (
        .pclk          (pclk),
        .lut_a_address (a_addr),
        .lut_b_address (b_addr),
        .ctrl_in_zero  (zero),
        .ctrl_in_one   (one),
        .ctrl_in_two   (two),
        .cell_clk      (cclk)
    );

    ldr_cell i_dut (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .lut_a_address (a_addr),
        .lut_b_address (b_addr),
        .ctrl_in_zero  (zero),
        .ctrl_in_one   (one),
        .ctrl_in_two   (two),
        .cell_clk      (cclk),
        .lut_a_out     (lut_a_out),
        .lut_b_out     (lut_b_out),
        .lut_a_ff      (lut_a_ff),
        .lut_b_ff      (lut_b_ff),
        .h_out         (h_out)
    );

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; read data and error flag are compared at the ready edge.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] exp, input logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        check({31'h0, pready}, 32'h1);
        check({31'h0, pslverr}, {31'h0, err});
        if (!w)
            check(prdata, exp);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic outs(input logic ea, input logic eb);
        i_user.wait_clk(8);
        check({30'h0, lut_b_out, lut_a_out}, {30'h0, eb, ea});
    endtask : outs

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, LDR_OFF_CFG, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, LDR_OFF_LOGIC, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, 8'h10, 32'hffff_ffff, 32'h0, 1'b1);
        xfer(1'b1, LDR_OFF_STATUS, 32'hffff_ffff, 32'h0, 1'b0);
        xfer(1'b0, LDR_OFF_STATUS, 32'h0, 32'h0, 1'b0);
        // Two 16x1 memories with separate addresses, synchronous rising edge.
        xfer(1'b1, LDR_OFF_CFG, 32'h3, 32'h0, 1'b0);
        i_user.drive(4'h5, 4'h9, 1'b1, 1'b1, 1'b1);
        i_user.wait_clk(10);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h0, 1'b0);
        i_user.cell_pulse();
        i_user.drive(4'h5, 4'h9, 1'b1, 1'b1, 1'b0);
        outs(1'b1, 1'b1);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h0200_0020, 1'b0);
        i_user.drive(4'h6, 4'h9, 1'b0, 1'b0, 1'b0);
        outs(1'b0, 1'b1);
        // Asynchronous strobe writes both tables without a cell clock edge.
        xfer(1'b1, LDR_OFF_CONTENT, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, LDR_OFF_CFG, 32'hb, 32'h0, 1'b0);
        i_user.drive(4'h2, 4'h3, 1'b1, 1'b1, 1'b1);
        i_user.wait_clk(6);
        i_user.drive(4'h2, 4'h3, 1'b1, 1'b1, 1'b0);
        i_user.wait_clk(6);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h0008_0004, 1'b0);
        // One 32x1 memory: the high data bit is the fifth address bit.
        xfer(1'b1, LDR_OFF_CONTENT, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, LDR_OFF_CFG, 32'h4, 32'h0, 1'b0);
        i_user.drive(4'h3, 4'h0, 1'b1, 1'b1, 1'b1);
        i_user.cell_pulse();
        i_user.drive(4'h3, 4'h0, 1'b0, 1'b1, 1'b0);
        outs(1'b1, 1'b1);
        i_user.drive(4'h3, 4'h0, 1'b0, 1'b0, 1'b0);
        outs(1'b0, 1'b0);
        // Dual port: write one address, then read it back on both ports.
        xfer(1'b1, LDR_OFF_CONTENT, 32'h0, 32'h0, 1'b0);
        xfer(1'b1, LDR_OFF_CFG, 32'h5, 32'h0, 1'b0);
        i_user.drive(4'h7, 4'h7, 1'b1, 1'b0, 1'b1);
        i_user.cell_pulse();
        i_user.drive(4'h7, 4'h7, 1'b0, 1'b0, 1'b0);
        outs(1'b1, 1'b1);
        i_user.drive(4'h7, 4'h4, 1'b0, 1'b0, 1'b0);
        outs(1'b1, 1'b0);
        // Table A as memory while table B keeps a logic function.
        xfer(1'b1, LDR_OFF_CFG, 32'h1, 32'h0, 1'b0);
        xfer(1'b1, LDR_OFF_LOGIC, 32'h0010_0000, 32'h0, 1'b0);
        i_user.drive(4'h0, 4'h4, 1'b0, 1'b0, 1'b0);
        outs(1'b0, 1'b1);
        i_user.cell_pulse();
        check({30'h0, lut_b_ff, lut_a_ff}, 32'h2);
        xfer(1'b0, LDR_OFF_STATUS, 32'h0, 32'h0000_000a, 1'b0);
        // Preloaded contents read the same way in two modes.
        xfer(1'b1, LDR_OFF_CONTENT, 32'h1234_a5c3, 32'h0, 1'b0);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h1234_a5c3, 1'b0);
        xfer(1'b1, LDR_OFF_CFG, 32'h3, 32'h0, 1'b0);
        i_user.drive(4'h0, 4'h2, 1'b0, 1'b0, 1'b0);
        outs(1'b1, 1'b1);
        xfer(1'b1, LDR_OFF_CFG, 32'h5, 32'h0, 1'b0);
        outs(1'b1, 1'b1);
        // Table B as memory on the falling cell clock edge, H function of the high data bit and both outputs.
        xfer(1'b1, LDR_OFF_CFG, 32'h412, 32'h0, 1'b0);
        i_user.drive(4'h0, 4'hf, 1'b0, 1'b1, 1'b1);
        i_user.cell_set(1'b1);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h1234_a5c3, 1'b0);
        check({30'h0, lut_b_ff, lut_a_ff}, 32'h2);
        i_user.cell_set(1'b0);
        check({30'h0, lut_b_ff, lut_a_ff}, 32'h0);
        i_user.drive(4'h0, 4'hf, 1'b0, 1'b1, 1'b0);
        outs(1'b0, 1'b1);
        check({31'h0, h_out}, 32'h1);
        xfer(1'b0, LDR_OFF_STATUS, 32'h0, 32'h0000_0012, 1'b0);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h9234_a5c3, 1'b0);
        // A reset in mid-run clears the setup but keeps the table contents.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, LDR_OFF_CFG, 32'h0, 32'h0, 1'b0);
        xfer(1'b0, LDR_OFF_CONTENT, 32'h0, 32'h9234_a5c3, 1'b0);
        end_of_test();
    end
endmodule : ldr_cell_test
`default_nettype wire

// [tb/ldr_user_model.sv]
// Model of the cell user logic that drives the table address, data, enable and clock pins.
`timescale 1ns/10ps
`default_nettype none
module ldr_user_model (
    input  wire logic       pclk,
    output var  logic [3:0] lut_a_address,
    output var  logic [3:0] lut_b_address,
    output var  logic       ctrl_in_zero,
    output var  logic       ctrl_in_one,
    output var  logic       ctrl_in_two,
    output var  logic       cell_clk
);
    initial
    begin
        lut_a_address = 4'h0;
        lut_b_address = 4'h0;
        ctrl_in_zero  = 1'b0;
        ctrl_in_one   = 1'b0;
        ctrl_in_two   = 1'b0;
        cell_clk      = 1'b0;
    end

    // Sets both addresses, both data bits and write enable after a clock edge.
    task automatic drive(input logic [3:0] a, input logic [3:0] b, input logic lo,
                         input logic hi, input logic we);
        @(posedge pclk);
        lut_a_address <= a;
        lut_b_address <= b;
        ctrl_in_two   <= lo;
        ctrl_in_one   <= hi;
        ctrl_in_zero  <= we;
    endtask : drive

    task automatic wait_clk(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_clk

    // Pulses the cell clock; pins stay still at least four cycles around each edge.
    task automatic cell_pulse();
        wait_clk(4);
        cell_clk <= 1'b1;
        wait_clk(4);
        cell_clk <= 1'b0;
        wait_clk(4);
    endtask : cell_pulse

    // Moves the cell clock to one level with quiet cycles on both sides.
    task automatic cell_set(input logic v);
        wait_clk(4);
        cell_clk <= v;
        wait_clk(4);
    endtask : cell_set
endmodule : ldr_user_model
`default_nettype wire
